// *** core/ebct_timer.sv ***
/*
 * Eight-bit compare timer with two match constants, output pin and
 * three interrupt request lines, registers on Avalon-MM.
 * Assumes 100 MHz clk_sys; pins external_count_input and counter reset
 * are asynchronous and synchronised here.
 */
// Contract
// - Counter steps once per period of the selected source, twice with both-edge external counting.
// - External input counts on rising, falling or both edges per selection.
// - Match flags A and B set when counter equals their constant.
// - Match pulse fires in last cycle of equality, together with the step leaving it.
// - On match, output keeps, goes low, goes high or toggles per field.
// - Clear selection zeroes counter on match A or match B.
// - With clear selection 11, external reset rising edge zeroes the counter.
// - Wrap flag sets when counter increments from FF to 00, not when cleared or written to 00.
// - Three interrupt lines, each flag AND its enable.
// - Priority A, B, wrap; only A and B serviceable by transfer controller.
// - Transfer controller service clears the matching flag.
// - Clear beats a simultaneous counter write.
// - Counter write beats a simultaneous increment.
// - Constant write suppresses a simultaneous match pulse.
// - Simultaneous match actions resolve toggle, high, low, keep.
// - Internal steps come from tap falling edges, switching included.
// - Switching from an internal source to another internal source or to stop may add one step.
// - Source codes 000/100 stop, 001 /8, 010 /64, 011 /1024, 101-111 external.
// - Output codes keep, low, high, toggle; low at start; undriven if all zero.
// - Software clears flags by reading set then writing zero only.
// - Clear codes 00 none, 01 match A, 10 match B, 11 external reset.
`timescale 1ns/1ns
module ebct_timer (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic external_count_input,
    input wire logic external_reset_input,
    input wire logic serviced_a,
    input wire logic serviced_b,
    output logic timer_output_pin,
    output logic timer_output_oe,
    output logic match_a_irq,
    output logic match_b_irq,
    output logic wrap_irq,
    output logic match_a_xfer_req,
    output logic match_b_xfer_req,
    output logic [1:0] irq_top_id
);
    import ebct_pkg::*;

    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0] count_value;
    logic [7:0] match_constant_a;
    logic [7:0] match_constant_b;
    logic [7:0] timer_control;
    ebct_out_sel_s out_sel;
    logic match_flag_a;
    logic match_flag_b;
    logic wrap_flag;
    logic [2:0] seen_set;
    logic tap_sel_d;
    logic out_level;
    logic ack;

    logic [2:0] taps;
    logic ext_rise;
    logic ext_fall;
    logic rst_rise;

    // ************************************************************
    // Source selection and step pulse
    // ************************************************************
    logic [2:0] source_sel;
    logic [1:0] clear_sel;
    logic tap_sel;
    logic step;
    logic is_internal;

    assign source_sel = timer_control[EBCT_CTL_SRC_LO +: 3];
    assign clear_sel = timer_control[EBCT_CTL_CLR_LO +: 2];
    assign is_internal = ~source_sel[2] & (source_sel[1:0] != 2'h0);

    ebct_prescaler #(
        .WIDTH(EBCT_PRESCALE_W)
    ) u_prescaler (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .taps(taps)
    );

    ebct_edge_sync u_count_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin(external_count_input),
        .level(),
        .rise(ext_rise),
        .fall(ext_fall)
    );

    ebct_edge_sync u_reset_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin(external_reset_input),
        .level(),
        .rise(rst_rise),
        .fall()
    );

    // Stopped state and external sources read as low, so a switch from a
    // high tap to a stop code is a falling edge and steps once; external codes step on pin edges only
    always_comb begin
        case (source_sel)
            3'h1: tap_sel = taps[0];
            3'h2: tap_sel = taps[1];
            3'h3: tap_sel = taps[2];
            default: tap_sel = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tap_sel_d <= 1'b0;
        end else begin
            tap_sel_d <= tap_sel;
        end
    end

    always_comb begin
        case (source_sel)
            EBCT_SRC_EXT_RISE: step = ext_rise;
            EBCT_SRC_EXT_FALL: step = ext_fall;
            EBCT_SRC_EXT_BOTH: step = ext_rise | ext_fall;
            default: step = tap_sel_d & ~tap_sel;
        endcase
    end

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic wr_count;
    logic wr_ma;
    logic wr_mb;
    logic wr_ctl;
    logic wr_st;
    logic rd_st;

    assign wr_count = avs_write & avs_byteenable[0] & (avs_address == 5'(EBCT_OFF_COUNT));
    assign wr_ma = avs_write & avs_byteenable[0] & (avs_address == 5'(EBCT_OFF_MATCH_A));
    assign wr_mb = avs_write & avs_byteenable[0] & (avs_address == 5'(EBCT_OFF_MATCH_B));
    assign wr_ctl = avs_write & avs_byteenable[0] & (avs_address == 5'(EBCT_OFF_CONTROL));
    assign wr_st = avs_write & avs_byteenable[0] & (avs_address == EBCT_OFF_STATUS);
    assign rd_st = avs_read & ~ack & (avs_address == EBCT_OFF_STATUS);

    // One wait cycle per access; the access lands on the edge of the ack
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read | avs_write) & ~ack;
        end
    end

    // ************************************************************
    // Compare and match pulses
    // ************************************************************
    logic match_a;
    logic match_b;
    logic do_clear;
    logic [7:0] next_count;

    // Pulse in the last cycle of equality, i.e. with the step leaving it
    assign match_a = step & (count_value == match_constant_a) & ~(wr_ma & ack);
    assign match_b = step & (count_value == match_constant_b) & ~(wr_mb & ack);

    always_comb begin
        case (clear_sel)
            EBCT_CLR_A: do_clear = match_a;
            EBCT_CLR_B: do_clear = match_b;
            EBCT_CLR_EXT: do_clear = rst_rise;
            default: do_clear = 1'b0;
        endcase
    end

    always_comb begin
        if (do_clear) begin
            next_count = EBCT_COUNT_RST;
        end else if (wr_count & ack) begin
            next_count = avs_writedata[7:0];
        end else if (step) begin
            next_count = count_value + 8'h01;
        end else begin
            next_count = count_value;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_value <= EBCT_COUNT_RST;
        end else begin
            count_value <= next_count;
        end
    end

    // ************************************************************
    // Registers written by software
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            match_constant_a <= EBCT_MATCH_RST;
            match_constant_b <= EBCT_MATCH_RST;
            timer_control <= EBCT_CONTROL_RST;
            out_sel <= '0;
        end else if (ack) begin
            if (wr_ma) begin
                match_constant_a <= avs_writedata[7:0];
            end
            if (wr_mb) begin
                match_constant_b <= avs_writedata[7:0];
            end
            if (wr_ctl) begin
                timer_control <= avs_writedata[7:0];
            end
            if (wr_st) begin
                out_sel <= avs_writedata[3:0];
            end
        end
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    logic wrap;
    logic [2:0] sw_clr;
    logic [2:0] flags;

    assign wrap = step & ~do_clear & ~(wr_count & ack) & (count_value == 8'hFF);
    assign flags = {match_flag_b, match_flag_a, wrap_flag};
    // A zero clears only a flag that was read while set
    assign sw_clr = (wr_st & ack) ? (seen_set & ~avs_writedata[7:5]) : 3'h0;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            match_flag_b <= 1'b0;
            match_flag_a <= 1'b0;
            wrap_flag <= 1'b0;
        end else begin
            // Set wins over every clear
            match_flag_b <= match_b | (match_flag_b & ~sw_clr[2] & ~serviced_b);
            match_flag_a <= match_a | (match_flag_a & ~sw_clr[1] & ~serviced_a);
            wrap_flag <= wrap | (wrap_flag & ~sw_clr[0]);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seen_set <= 3'h0;
        end else if (rd_st) begin
            seen_set <= flags;
        end else if (wr_st & ack) begin
            seen_set <= 3'h0;
        end
    end

    // ************************************************************
    // Timer output
    // ************************************************************
    function automatic logic [1:0] ebct_rank(input logic [1:0] sel, input logic hit);
        ebct_rank = hit ? sel : EBCT_OUT_KEEP;
    endfunction : ebct_rank

    logic [1:0] act_a;
    logic [1:0] act_b;
    logic [1:0] act;

    assign act_a = ebct_rank(out_sel.sel_a, match_a);
    assign act_b = ebct_rank(out_sel.sel_b, match_b);
    // Codes already rise in precedence: keep, low, high, toggle
    assign act = (act_a > act_b) ? act_a : act_b;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_level <= 1'b0;
        end else begin
            case (act)
                EBCT_OUT_LOW: out_level <= 1'b0;
                EBCT_OUT_HIGH: out_level <= 1'b1;
                EBCT_OUT_TOGGLE: out_level <= ~out_level;
                default: out_level <= out_level;
            endcase
        end
    end

    assign timer_output_pin = out_level;
    assign timer_output_oe = (out_sel != '0);

    // ************************************************************
    // Interrupt requests
    // ************************************************************
    assign match_a_irq = match_flag_a & timer_control[EBCT_CTL_IE_A];
    assign match_b_irq = match_flag_b & timer_control[EBCT_CTL_IE_B];
    assign wrap_irq = wrap_flag & timer_control[EBCT_CTL_IE_W];
    assign match_a_xfer_req = match_a_irq;
    assign match_b_xfer_req = match_b_irq;

    always_comb begin
        if (match_a_irq) begin
            irq_top_id = 2'h1;
        end else if (match_b_irq) begin
            irq_top_id = 2'h2;
        end else if (wrap_irq) begin
            irq_top_id = 2'h3;
        end else begin
            irq_top_id = 2'h0;
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0;
        end else if (avs_read & ~ack) begin
            case (avs_address)
                5'(EBCT_OFF_COUNT): avs_readdata <= {24'h0, count_value};
                5'(EBCT_OFF_MATCH_A): avs_readdata <= {24'h0, match_constant_a};
                5'(EBCT_OFF_MATCH_B): avs_readdata <= {24'h0, match_constant_b};
                5'(EBCT_OFF_CONTROL): avs_readdata <= {24'h0, timer_control};
                EBCT_OFF_STATUS: avs_readdata <= {24'h0, flags, 1'b1, out_sel};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

endmodule : ebct_timer

// *** common/ebct_pkg.sv ***
/*
 * Shared constants and types of the eight-bit compare timer.
 * Assumes a 100 MHz system clock and a 32-bit Avalon-MM register port.
 */
package ebct_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [3:0] EBCT_OFF_COUNT = 4'h0;
    localparam logic [3:0] EBCT_OFF_MATCH_A = 4'h4;
    localparam logic [3:0] EBCT_OFF_MATCH_B = 4'h8;
    localparam logic [3:0] EBCT_OFF_CONTROL = 4'hC;
    localparam logic [4:0] EBCT_OFF_STATUS = 5'h10;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int EBCT_CTL_IE_B = 7;
    localparam int EBCT_CTL_IE_A = 6;
    localparam int EBCT_CTL_IE_W = 5;
    localparam int EBCT_CTL_CLR_LO = 3;
    localparam int EBCT_CTL_SRC_LO = 0;
    localparam int EBCT_ST_FLAG_B = 7;
    localparam int EBCT_ST_FLAG_A = 6;
    localparam int EBCT_ST_FLAG_W = 5;
    localparam int EBCT_ST_RSVD = 4;
    localparam logic [7:0] EBCT_CONTROL_RST = 8'h00;
    localparam logic [7:0] EBCT_STATUS_RST = 8'h10;
    localparam logic [7:0] EBCT_COUNT_RST = 8'h00;
    localparam logic [7:0] EBCT_MATCH_RST = 8'hFF;

    // ************************************************************
    // Encodings
    // ************************************************************
    localparam logic [2:0] EBCT_SRC_EXT_RISE = 3'h5;
    localparam logic [2:0] EBCT_SRC_EXT_FALL = 3'h6;
    localparam logic [2:0] EBCT_SRC_EXT_BOTH = 3'h7;
    localparam logic [1:0] EBCT_CLR_NONE = 2'h0;
    localparam logic [1:0] EBCT_CLR_A = 2'h1;
    localparam logic [1:0] EBCT_CLR_B = 2'h2;
    localparam logic [1:0] EBCT_CLR_EXT = 2'h3;
    localparam logic [1:0] EBCT_OUT_KEEP = 2'h0;
    localparam logic [1:0] EBCT_OUT_LOW = 2'h1;
    localparam logic [1:0] EBCT_OUT_HIGH = 2'h2;
    localparam logic [1:0] EBCT_OUT_TOGGLE = 2'h3;

    // ************************************************************
    // Prescaler divisions
    // ************************************************************
    localparam int EBCT_DIV_1 = 8;
    localparam int EBCT_DIV_2 = 64;
    localparam int EBCT_DIV_3 = 1024;
    localparam int EBCT_PRESCALE_W = 10;

    typedef struct packed {
        logic [1:0] sel_b;
        logic [1:0] sel_a;
    } ebct_out_sel_s;

endpackage : ebct_pkg

// *** core/ebct_edge_sync.sv ***
/*
 * Two-stage synchroniser with rise and fall pulses on the synchronised level.
 * Assumes an asynchronous pin input and one system clock.
 */
`timescale 1ns/1ns
module ebct_edge_sync (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    import ebct_pkg::*;

    logic meta;
    logic sync;
    logic sync_d;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            sync <= 1'b0;
            sync_d <= 1'b0;
        end else begin
            meta <= pin;
            sync <= meta;
            sync_d <= sync;
        end
    end

    assign level = sync;
    assign rise = sync & ~sync_d;
    assign fall = ~sync & sync_d;

endmodule : ebct_edge_sync

// *** core/ebct_prescaler.sv ***
/*
 * Free-running system clock divider giving the three internal tap levels.
 * Assumes one system clock; the taps are square waves of the named division.
 */
`timescale 1ns/1ns
module ebct_prescaler #(
    parameter int WIDTH = ebct_pkg::EBCT_PRESCALE_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    output logic [2:0] taps
);
    import ebct_pkg::*;

    logic [WIDTH-1:0] div;

    // Elaboration check: the widest tap must fit in the divider
    if ((1 << WIDTH) < EBCT_DIV_3) begin : g_width_check
        $error("ebct_prescaler: WIDTH too small");
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end

    // Tap bit n of a counter is a square wave of period 2^(n+1)
    assign taps[0] = div[$clog2(EBCT_DIV_1) - 1];
    assign taps[1] = div[$clog2(EBCT_DIV_2) - 1];
    assign taps[2] = div[$clog2(EBCT_DIV_3) - 1];

endmodule : ebct_prescaler

// *** verification/ebct_timer_chk.sv ***
/* Checker of the timer's register port and request lines.
   Bound to ebct_timer below; sees only that module's ports. */
`timescale 1ns/1ns
module ebct_timer_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic timer_output_oe,
    input wire logic serviced_a,
    input wire logic serviced_b,
    input wire logic match_a_irq,
    input wire logic match_b_irq,
    input wire logic wrap_irq,
    input wire logic match_a_xfer_req,
    input wire logic match_b_xfer_req,
    input wire logic [1:0] irq_top_id
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic ack_rd;
    logic st_wr;
    assign ack_rd = avs_read && !avs_waitrequest;
    assign st_wr = avs_write && !avs_waitrequest && avs_address == 5'h10;
    // ************************************************************
    // Properties
    // ************************************************************
    property p_xfer;
        match_a_xfer_req == match_a_irq && match_b_xfer_req == match_b_irq;
    endproperty
    a_xfer: assert property (p_xfer) else $error("transfer request differs from irq");
    property p_top_id;
        irq_top_id == (match_a_irq ? 2'h1 : match_b_irq ? 2'h2 : wrap_irq ? 2'h3 : 2'h0);
    endproperty
    a_top_id: assert property (p_top_id) else $error("wrong top request id");
    property p_one_wait;
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait cycle count wrong");
    property p_rd_upper;
        ack_rd |-> avs_readdata[31:8] == 24'h000000 && (avs_address != 5'h10 || avs_readdata[4]);
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits wrong");
    property p_serv_a;
        serviced_a && match_a_irq |=> !match_a_irq;
    endproperty
    a_serv_a: assert property (p_serv_a) else $error("service left flag A set");
    property p_serv_b;
        serviced_b && match_b_irq |=> !match_b_irq;
    endproperty
    a_serv_b: assert property (p_serv_b) else $error("service left flag B set");
    property p_one_no_set;
        st_wr && avs_writedata[5] && !wrap_irq |=> !wrap_irq;
    endproperty
    a_one_no_set: assert property (p_one_no_set) else $error("write of one set a flag");
    property p_oe_cause;
        $changed(timer_output_oe) |-> $past(st_wr) || $past(st_wr, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("output enable moved alone");
endmodule : ebct_timer_chk

bind ebct_timer ebct_timer_chk i_ebct_timer_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timer_output_oe(timer_output_oe),
    .serviced_a(serviced_a), .serviced_b(serviced_b), .match_a_irq(match_a_irq),
    .match_b_irq(match_b_irq), .wrap_irq(wrap_irq), .match_a_xfer_req(match_a_xfer_req),
    .match_b_xfer_req(match_b_xfer_req), .irq_top_id(irq_top_id)
);

// *** verification/ebct_far_model.sv ***
/* Far side of the timer: count and reset pin source, transfer controller.
   Assumes the timer's clock; pins change just after a rising edge. */
`timescale 1ns/1ns
module ebct_far_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic match_a_xfer_req,
    input wire logic match_b_xfer_req,
    input wire logic serve_en,
    input wire logic [3:0] serve_wait,
    output logic serviced_a,
    output logic serviced_b,
    output logic external_count_input,
    output logic external_reset_input
);
    // ************************************************************
    // Pin pulses: 4 clocks each level, above the both-edge minimum
    // ************************************************************
    task automatic pulse_count(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            external_count_input <= 1'b1;
            repeat (4) @(posedge clk_sys);
            external_count_input <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
    endtask : pulse_count
    task automatic pulse_reset();
        @(posedge clk_sys);
        external_reset_input <= 1'b1;
        repeat (4) @(posedge clk_sys);
        external_reset_input <= 1'b0;
    endtask : pulse_reset
    initial begin
        external_count_input = 1'b0;
        external_reset_input = 1'b0;
        serviced_a = 1'b0;
        serviced_b = 1'b0;
        forever begin
            @(posedge clk_sys);
            // Only the compare requests are serviceable; A goes first
            if (serve_en && rst_n && (match_a_xfer_req || match_b_xfer_req)) begin
                repeat (serve_wait) @(posedge clk_sys);
                serviced_a <= match_a_xfer_req;
                serviced_b <= !match_a_xfer_req && match_b_xfer_req;
                @(posedge clk_sys);
                serviced_a <= 1'b0;
                serviced_b <= 1'b0;
            end
        end
    end
endmodule : ebct_far_model

// *** verification/tb_top.sv ***
/* Self-checking bench of the eight-bit compare timer.
   Avalon-MM master tasks; pins and service come from ebct_far_model. */
`timescale 1ns/1ns
module tb_top;
    import ebct_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, serviced_a, serviced_b, ext_cnt, ext_rst;
    logic pin, oe, irq_a, irq_b, irq_w, req_a, req_b;
    logic [1:0] top_id;
    logic serve_en = 1'b0;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    int dv [5] = '{0, EBCT_DIV_1, EBCT_DIV_2, EBCT_DIV_3, 0};
    always #5 clk_sys = ~clk_sys;
    ebct_timer i_ebct_timer (
        .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .external_count_input(ext_cnt), .external_reset_input(ext_rst),
        .serviced_a(serviced_a), .serviced_b(serviced_b), .timer_output_pin(pin),
        .timer_output_oe(oe), .match_a_irq(irq_a), .match_b_irq(irq_b), .wrap_irq(irq_w),
        .match_a_xfer_req(req_a), .match_b_xfer_req(req_b), .irq_top_id(top_id)
    );
    ebct_far_model i_ebct_far_model (
        .clk_sys(clk_sys), .rst_n(rst_n), .match_a_xfer_req(req_a),
        .match_b_xfer_req(req_b), .serve_en(serve_en), .serve_wait(4'hF),
        .serviced_a(serviced_a), .serviced_b(serviced_b),
        .external_count_input(ext_cnt), .external_reset_input(ext_rst)
    );
    // ************************************************************
    // Bus and comparison tasks
    // ************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Waitrequest is sampled at each rising edge; the request stands until it is low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(negedge clk_sys);
    endtask : bus
    task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(rd[7:0], exp);
    endtask : rchk
    task automatic pulses(input int n);
        i_ebct_far_model.pulse_count(n);
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : pulses
    task automatic tally_and_finish();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rchk(5'h00, EBCT_COUNT_RST);
        rchk(5'h04, EBCT_MATCH_RST);
        rchk(5'h08, EBCT_MATCH_RST);
        rchk(5'h0C, EBCT_CONTROL_RST);
        rchk(5'h10, EBCT_STATUS_RST);
        bus(1'b1, 5'h14, 8'h5A);
        rchk(5'h14, 8'h00);
        // Control first, then zero the count: a source switch may add a step
        for (int c = 0; c < 5; c++) begin
            bus(1'b1, 5'h0C, {5'h00, c[2:0]});
            bus(1'b1, 5'h00, 8'h00);
            repeat ((dv[c] == 0) ? 100 : 6 * dv[c]) @(posedge clk_sys);
            bus(1'b0, 5'h00, 8'h00);
            if (dv[c] == 0)
                check(rd[7:0], 8'h00);
            else
                check(8'(rd[7:0] > 8'h04 && rd[7:0] < 8'h09), 8'h01);
        end
        for (int c = 5; c < 8; c++) begin
            bus(1'b1, 5'h0C, {5'h00, c[2:0]});
            bus(1'b1, 5'h00, 8'h00);
            pulses(3);
            rchk(5'h00, (c == 7) ? 8'h06 : 8'h03);
        end
        // Equal constants, A toggles and B drives low: toggle must win
        bus(1'b1, 5'h04, 8'h03);
        bus(1'b1, 5'h08, 8'h03);
        bus(1'b1, 5'h10, 8'h07);
        bus(1'b1, 5'h0C, 8'hED);
        bus(1'b1, 5'h00, 8'h00);
        check({6'h00, oe, pin}, 8'h02);
        pulses(3);
        check({6'h00, irq_a, pin}, 8'h00);
        rchk(5'h00, 8'h03);
        pulses(1);
        rchk(5'h00, 8'h00);
        check({1'b0, irq_a, irq_b, req_a, req_b, pin, top_id}, 8'h7D);
        serve_en <= 1'b1;
        wait (irq_a === 1'b0);
        @(negedge clk_sys);
        check({5'h00, irq_b, top_id}, 8'h06);
        wait (irq_b === 1'b0);
        @(negedge clk_sys);
        check({6'h00, top_id}, 8'h00);
        serve_en <= 1'b0;
        bus(1'b1, 5'h0C, 8'hE5);
        bus(1'b1, 5'h00, 8'hFE);
        pulses(2);
        rchk(5'h00, 8'h00);
        check({5'h00, irq_w, top_id}, 8'h07);
        bus(1'b1, 5'h10, 8'h07);
        check(8'(irq_w), 8'h01);
        rchk(5'h10, 8'h37);
        bus(1'b1, 5'h10, 8'h07);
        check(8'(irq_w), 8'h00);
        bus(1'b1, 5'h10, 8'hE7);
        rchk(5'h10, 8'h17);
        bus(1'b1, 5'h08, 8'h02);
        bus(1'b1, 5'h0C, 8'h15);
        bus(1'b1, 5'h00, 8'h00);
        pulses(3);
        rchk(5'h00, 8'h00);
        check(8'(pin), 8'h00);
        bus(1'b1, 5'h10, 8'h0B);
        bus(1'b1, 5'h0C, 8'h1D);
        pulses(3);
        rchk(5'h00, 8'h03);
        check(8'(pin), 8'h01);
        i_ebct_far_model.pulse_reset();
        repeat (6) @(posedge clk_sys);
        rchk(5'h00, 8'h00);
        tally_and_finish();
    end
endmodule : tb_top
